/* event_trace_pkg.sv */
// Constants and carrier types for the event-trace read image block
`default_nettype none
package event_trace_pkg;
   // Timing: one event_time_us step per microsecond
   localparam int CLK_PERIOD_NS = 20;
   localparam int TICK_US_NS    = 1000;
   localparam int TICK_CYCLES   = TICK_US_NS / CLK_PERIOD_NS;
   // Buffer and image layout, byte offsets into the image
   localparam int ENTRY_DEPTH   = 1000;
   localparam int ENTRY_BYTES   = 6;
   localparam int HDR_BYTES     = 6;
   localparam int STATUS_OFS    = 4;
   localparam int VER_HI_OFS    = 4;
   localparam int VER_LO_OFS    = 5;
   localparam int FW_OFS        = 8;
   localparam int MODID_OFS     = 12;
   localparam int CFG_BASE      = 16;
   localparam int CFG_LAST      = 203;
   localparam int CFG_BYTES     = CFG_LAST - CFG_BASE + 1;
   localparam int COUNT_OFS     = 204;
   localparam int ENTRY_BASE    = 206;
   // Register byte offsets
   localparam logic [7:0] OFS_CTRL     = 8'h00;
   localparam logic [7:0] OFS_STATUS   = 8'h04;
   localparam logic [7:0] OFS_IMG_PTR  = 8'h08;
   localparam logic [7:0] OFS_IMG_DATA = 8'h0c;
   localparam logic [7:0] OFS_CFG_IDX  = 8'h10;
   localparam logic [7:0] OFS_CFG_DATA = 8'h14;
   localparam logic [7:0] OFS_COUNT    = 8'h18;
   // Control and status field positions
   localparam int BIT_DIAG    = 0;
   localparam int BIT_MODE    = 1;
   localparam int BIT_STARTED = 2;
   localparam int BIT_DONE    = 3;
   // Reset values: diagnostics on, reading mode
   localparam logic DIAG_RST = 1'b1;
   localparam logic MODE_RST = 1'b1;
   // Classic Wishbone request from the master
   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [7:0]  adr;
      logic [3:0]  sel;
      logic [31:0] dat;
   } wb_req_s;
   // Event offered by the serial logic
   typedef struct packed {
      logic       valid;
      logic [7:0] code;
      logic [7:0] detail;
   } event_in_s;
   // Stored ring entry
   typedef struct packed {
      logic [31:0] timeUs;
      logic [7:0]  code;
      logic [7:0]  detail;
   } event_entry_s;
endpackage
`default_nettype wire

/* event_trace_readout.sv */
// Event-trace ring buffer with byte-serial read image over Wishbone
`default_nettype none
module event_trace_readout #(
   parameter int          DEPTH      = event_trace_pkg::ENTRY_DEPTH,
   parameter logic [7:0]  VER_HI     = 8'h01,
   parameter logic [7:0]  VER_LO     = 8'h00,
   parameter logic [31:0] FW_VERSION = 32'h5601_0000,
   parameter logic [31:0] MODULE_ID  = 32'h0000_0a5c  // Arbitrary value
) (
   // Clock, reset, enable
   input  wire logic                     sys_clk,
   input  wire logic                     rst_b,
   input  wire logic                     ce,
   // Wishbone slave
   input  wire event_trace_pkg::wb_req_s wbReq,
   output var  logic                     wb_ack_o,
   output var  logic [31:0]              wb_dat_o,
   // Events from the serial logic
   input  wire event_trace_pkg::event_in_s evtIn
);
   import event_trace_pkg::*;

   localparam int SW = $clog2(DEPTH);
   localparam logic [SW-1:0] LAST_SLOT = SW'(DEPTH - 1);
   localparam logic [15:0]   ENTRY_IDX = 16'(HDR_BYTES + ENTRY_BASE);

   // Ring slot advance with wrap
   function automatic logic [SW-1:0] nextSlot(input logic [SW-1:0] s);
      nextSlot = (s == LAST_SLOT) ? '0 : s + SW'(1);
   endfunction

   // Byte k of a word, most significant byte first
   function automatic logic [7:0] wordByte(input logic [31:0] w,
                                           input logic [1:0]  k);
      wordByte = w[8 * (3 - int'(k)) +: 8];
   endfunction

   // Storage
   event_entry_s entryMem [DEPTH];
   logic [7:0]   cfgMem   [CFG_BYTES];

   // State
   logic          diag_q, diag_d;
   logic          mode_q, mode_d;
   logic          started_q, started_d;
   logic          done_q, done_d;
   logic [SW-1:0] wrPtr_q, wrPtr_d;
   logic [SW:0]   count_q, count_d;
   logic [7:0]    tick_q, tick_d;
   logic [31:0]   timeUs_q, timeUs_d;
   logic [15:0]   byteIdx_q, byteIdx_d;
   logic [SW-1:0] slot_q, slot_d;
   logic [2:0]    sub_q, sub_d;
   logic [7:0]    cfgIdx_q, cfgIdx_d;
   logic          ack_q, ack_d;
   logic [31:0]   dat_q, dat_d;

   // Decoded bus and derived values
   logic          busReq, doW, doR, rec, clearRing;
   logic [7:0]    word;
   logic [15:0]   count16, totLen, lastIdx, d;
   logic [SW-1:0] oldest;
   logic [7:0]    imgByte, statusByte;
   event_entry_s  ent;

   // Bus decode; a request is taken once, before its ack
   always_comb begin
      busReq  = wbReq.cyc & wbReq.stb & ~ack_q;
      doW     = busReq & wbReq.we & wbReq.sel[0];
      doR     = busReq & ~wbReq.we;
      word    = {wbReq.adr[7:2], 2'b00};
      count16 = 16'(count_q);
      clearRing = doW & (word == OFS_CTRL) & ~wbReq.dat[BIT_DIAG];
      rec     = evtIn.valid & diag_q & ~mode_q;
   end

   // Oldest entry and image lengths
   always_comb begin
      if (count_q > (SW+1)'(LAST_SLOT)) begin
         oldest = wrPtr_q;  // Full: next slot to write holds the oldest
      end else if (SW'(count_q) <= wrPtr_q) begin
         oldest = wrPtr_q - SW'(count_q);
      end else begin
         oldest = SW'(DEPTH - 32'(count_q) + 32'(wrPtr_q));
      end
      totLen  = 16'(ENTRY_BASE) + 16'(ENTRY_BYTES) * count16;
      lastIdx = 16'(HDR_BYTES) + totLen - 16'h1;
      d       = byteIdx_q - 16'(HDR_BYTES);
      ent     = entryMem[slot_q];
      statusByte = {4'h0, done_q, started_q, mode_q, diag_q};
   end

   // Image byte at the read pointer
   always_comb begin
      imgByte = 8'h00;
      if (byteIdx_q < 16'(HDR_BYTES)) begin
         unique case (byteIdx_q[2:0])
            3'h1:    imgByte = 8'(HDR_BYTES);
            3'h2:    imgByte = totLen[15:8];
            3'h3:    imgByte = totLen[7:0];
            3'h4:    imgByte = statusByte;
            default: imgByte = 8'h00;  // byte 5 and high offset byte
         endcase
      end else if (byteIdx_q > lastIdx) begin
         imgByte = 8'h00;
      end else if (d < 16'(FW_OFS)) begin
         if (d == 16'(VER_HI_OFS)) imgByte = VER_HI;
         else if (d == 16'(VER_LO_OFS)) imgByte = VER_LO;
      end else if (d < 16'(MODID_OFS)) begin
         imgByte = wordByte(FW_VERSION, d[1:0]);
      end else if (d < 16'(CFG_BASE)) begin
         imgByte = wordByte(MODULE_ID, d[1:0]);
      end else if (d <= 16'(CFG_LAST)) begin
         imgByte = cfgMem[8'(d - 16'(CFG_BASE))];
      end else if (d < 16'(ENTRY_BASE)) begin
         imgByte = (d == 16'(COUNT_OFS)) ? count16[15:8] : count16[7:0];
      end else begin
         unique case (sub_q)
            3'h0:    imgByte = ent.timeUs[31:24];
            3'h1:    imgByte = ent.timeUs[23:16];
            3'h2:    imgByte = ent.timeUs[15:8];
            3'h3:    imgByte = ent.timeUs[7:0];
            3'h4:    imgByte = ent.code;
            default: imgByte = ent.detail;
         endcase
      end
   end

   // Control, status and mode next values
   always_comb begin
      diag_d    = diag_q;
      mode_d    = mode_q;
      started_d = started_q;
      done_d    = done_q;
      if (doW && word == OFS_CTRL) begin
         diag_d = wbReq.dat[BIT_DIAG];
         mode_d = wbReq.dat[BIT_MODE];
         if (!wbReq.dat[BIT_MODE] || !wbReq.dat[BIT_DIAG]) begin
            started_d = 1'b0;
            done_d    = 1'b0;
         end
      end
      if (doW && word == OFS_IMG_PTR && mode_q) begin
         started_d = 1'b1;
         done_d    = 1'b0;
      end
      if (doR && word == OFS_IMG_DATA && mode_q && byteIdx_q == lastIdx) begin
         done_d = 1'b1;
      end
   end

   // Ring pointers and event_time_us next values
   always_comb begin
      wrPtr_d  = wrPtr_q;
      count_d  = count_q;
      tick_d   = tick_q + 8'h1;
      timeUs_d = timeUs_q;
      if (tick_q == 8'(TICK_CYCLES - 1)) begin
         tick_d   = 8'h00;
         timeUs_d = timeUs_q + 32'h1;
      end
      if (clearRing) begin
         wrPtr_d = '0;
         count_d = '0;
      end else if (rec) begin
         wrPtr_d = nextSlot(wrPtr_q);
         if (count_q != (SW+1)'(DEPTH)) count_d = count_q + (SW+1)'(1);
      end
   end

   // Read pointer, config window and bus answer next values
   always_comb begin
      byteIdx_d = byteIdx_q;
      slot_d    = slot_q;
      sub_d     = sub_q;
      cfgIdx_d  = cfgIdx_q;
      ack_d     = busReq;
      dat_d     = 32'h0;
      if (doW && word == OFS_IMG_PTR) begin
         byteIdx_d = 16'h0;
         slot_d    = oldest;
         sub_d     = 3'h0;
      end
      if (doW && word == OFS_CFG_IDX) cfgIdx_d = wbReq.dat[7:0];
      if (doW && word == OFS_CFG_DATA) cfgIdx_d = cfgIdx_q + 8'h1;
      if (doR) begin
         unique case (word)
            OFS_CTRL:     dat_d = {30'h0, mode_q, diag_q};
            OFS_STATUS:   dat_d = {24'h0, statusByte};
            OFS_IMG_PTR:  dat_d = {16'h0, byteIdx_q};
            OFS_IMG_DATA: dat_d = {24'h0, imgByte};
            OFS_CFG_IDX:  dat_d = {24'h0, cfgIdx_q};
            OFS_CFG_DATA: dat_d = (cfgIdx_q < 8'(CFG_BYTES)) ?
                                  {24'h0, cfgMem[cfgIdx_q]} : 32'h0;
            OFS_COUNT:    dat_d = {16'h0, count16};
            default:      dat_d = 32'h0;
         endcase
      end
      // entries follow back to back, six bytes each
      if (doR && word == OFS_IMG_DATA && byteIdx_q <= lastIdx) begin
         byteIdx_d = byteIdx_q + 16'h1;
         if (byteIdx_q >= ENTRY_IDX) begin
            if (sub_q == 3'(ENTRY_BYTES - 1)) begin
               sub_d  = 3'h0;
               slot_d = nextSlot(slot_q);
            end else begin
               sub_d = sub_q + 3'h1;
            end
         end
      end
   end

   // Register all state
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         diag_q    <= DIAG_RST;
         mode_q    <= MODE_RST;
         started_q <= 1'b0;
         done_q    <= 1'b0;
         wrPtr_q   <= '0;
         count_q   <= '0;
         tick_q    <= 8'h00;
         timeUs_q  <= 32'h0;
         byteIdx_q <= 16'h0;
         slot_q    <= '0;
         sub_q     <= 3'h0;
         cfgIdx_q  <= 8'h00;
         ack_q     <= 1'b0;
         dat_q     <= 32'h0;
      end else if (ce) begin
         diag_q    <= diag_d;
         mode_q    <= mode_d;
         started_q <= started_d;
         done_q    <= done_d;
         wrPtr_q   <= wrPtr_d;
         count_q   <= count_d;
         tick_q    <= tick_d;
         timeUs_q  <= timeUs_d;
         byteIdx_q <= byteIdx_d;
         slot_q    <= slot_d;
         sub_q     <= sub_d;
         cfgIdx_q  <= cfgIdx_d;
         ack_q     <= ack_d;
         dat_q     <= dat_d;
      end
   end

   // Memory writes: ring entries and configuration copies
   always_ff @(posedge sys_clk) begin
      if (ce && rec && !clearRing) begin
         entryMem[wrPtr_q] <= '{timeUs_q, evtIn.code, evtIn.detail};
      end
      if (ce && doW && word == OFS_CFG_DATA && cfgIdx_q < 8'(CFG_BYTES)) begin
         cfgMem[cfgIdx_q] <= wbReq.dat[7:0];
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = dat_q;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);

   logic imgRd;
   assign imgRd = ce & doR & (word == OFS_IMG_DATA);

   AST_HDR_START: assert property (
      imgRd && byteIdx_q == 16'h1 |=> dat_q == {24'h0, 8'(HDR_BYTES)})
      else $error("Header start offset wrong");
   AST_STATUS_RSV: assert property (
      ce && doR && word == OFS_STATUS |=> dat_q[31:4] == 28'h0)
      else $error("Status reserved bits not zero");
   AST_BYTE5_ZERO: assert property (
      imgRd && byteIdx_q == 16'h5 |=> dat_q == 32'h0)
      else $error("Image byte 5 not zero");
   AST_STATUS_MODE: assert property (
      imgRd && byteIdx_q == 16'h4 |=> dat_q[1:0] == {mode_q, diag_q})
      else $error("Status mode bits wrong");
   AST_VERSION_HI: assert property (
      imgRd && byteIdx_q == 16'(HDR_BYTES + VER_HI_OFS)
      |=> dat_q == {24'h0, VER_HI})
      else $error("Block version high byte wrong");
   AST_FW_LETTER: assert property (
      imgRd && byteIdx_q == 16'(HDR_BYTES + FW_OFS)
      |=> dat_q[7:0] == FW_VERSION[31:24])
      else $error("Firmware letter wrong");
   AST_COUNT_LOW: assert property (
      imgRd && byteIdx_q == 16'(HDR_BYTES + COUNT_OFS + 1)
      |=> dat_q[7:0] == $past(count16[7:0]))
      else $error("Event count low byte wrong");
   AST_TICK: assert property (
      ce && tick_q == 8'(TICK_CYCLES - 1)
      |=> timeUs_q == $past(timeUs_q) + 32'h1)
      else $error("Event_time_us did not advance");
   AST_RING_WRAP: assert property (
      ce && rec && !clearRing && wrPtr_q == LAST_SLOT |=> wrPtr_q == '0)
      else $error("Ring did not wrap");
   AST_CLEAR: assert property (
      ce && clearRing |=> count_q == '0 && !diag_q ##1 count_q == '0)
      else $error("Deactivate did not clear ring");
   AST_SUSPEND: assert property (
      ce && mode_q && !doW |=> $stable(wrPtr_q) && $stable(count_q))
      else $error("Recording during reading mode");
   AST_ACK: assert property (
      ce && busReq |=> ack_q ##1 !ack_q)
      else $error("Bus answer not one cycle");
endmodule
`default_nettype wire

/* event_trace_host.sv */
// Wishbone classic master model standing for the controller CPU
`default_nettype none
module event_trace_host (
   // Clock
   input  wire logic                     sys_clk,
   // Wishbone master side
   output var  event_trace_pkg::wb_req_s wbReq,
   input  wire logic                     wbAck,
   input  wire logic [31:0]              wbDat
);
   timeunit 1ns;
   timeprecision 1ns;
   import event_trace_pkg::*;
   initial wbReq = '0;
   // One classic cycle, held until ack is sampled high
   task automatic xfer(input logic we, input logic [7:0] adr,
      input logic [7:0] dat, input logic [3:0] sel,
      output logic [31:0] rd);
      rd = 'x;
      @(posedge sys_clk);
      wbReq <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: sel,
                 dat: {24'h00_0000, dat}};
      // Only the bench watchdog ends a wait for ack
      do begin
         @(posedge sys_clk);
      end while (wbAck !== 1'b1);
      rd = wbDat;
      wbReq <= '0;
   endtask
endmodule
`default_nettype wire

/* event_trace_readout_tb.sv */
// Self-checking bench for the event-trace read image block
`default_nettype none
module event_trace_readout_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import event_trace_pkg::*;
   typedef struct packed {
      logic       we;
      logic [7:0] adr;
      logic [7:0] dat;
      logic [7:0] exp;
   } row_s;
   localparam int NKEEP = 3;
   localparam int NEVT  = 6;
   localparam int NIMG  = HDR_BYTES + ENTRY_BASE + ENTRY_BYTES * NKEEP;
   localparam logic [31:0] FW  = 32'h4102_0304;  // Arbitrary value
   localparam logic [31:0] MID = 32'h1122_3344;  // Arbitrary value
   logic        sys_clk;
   logic        rst_b;
   logic        ce;
   wb_req_s     wbReq;
   logic        wbAck;
   logic [31:0] wbDat;
   event_in_s   evtIn;
   logic [31:0] rd;
   logic [7:0]  img [0:255];
   logic [31:0] ts  [0:NKEEP-1];
   int          err_total;
   int          n_compared;
   int          i;
   int          e;
   // Plain accesses: direction, offset, write data, expected read
   row_s rows [0:15] = '{
      '{1'b0, OFS_STATUS, 8'h00, 8'h03}, '{1'b0, OFS_COUNT, 8'h00, 8'h00},
      '{1'b1, OFS_CFG_IDX, 8'h00, 8'h00}, '{1'b1, OFS_CFG_DATA, 8'ha5, 8'h00},
      '{1'b1, OFS_CFG_DATA, 8'h3c, 8'h00}, '{1'b1, OFS_CFG_IDX, 8'h00, 8'h00},
      '{1'b0, OFS_CFG_DATA, 8'h00, 8'ha5}, '{1'b1, OFS_CFG_IDX, 8'hbb, 8'h00},
      '{1'b1, OFS_CFG_DATA, 8'h5a, 8'h00}, '{1'b0, OFS_CFG_DATA, 8'h00, 8'h00},
      '{1'b0, 8'h1c, 8'h00, 8'h00}, '{1'b1, OFS_CTRL, 8'h01, 8'h00},
      '{1'b0, OFS_STATUS, 8'h00, 8'h01}, '{1'b0, OFS_CTRL, 8'h00, 8'h01},
      '{1'b0, OFS_CFG_IDX, 8'h00, 8'hbc}, '{1'b0, OFS_IMG_PTR, 8'h00, 8'h00}};
   event_trace_readout #(.DEPTH(NKEEP), .VER_HI(8'h02), .VER_LO(8'h07),
      .FW_VERSION(FW), .MODULE_ID(MID)) DUT (
      .sys_clk  (sys_clk),
      .rst_b    (rst_b),
      .ce       (ce),
      .wbReq    (wbReq),
      .wb_ack_o (wbAck),
      .wb_dat_o (wbDat),
      .evtIn    (evtIn));
   event_trace_host u_host (.sys_clk(sys_clk), .wbReq(wbReq),
      .wbAck(wbAck), .wbDat(wbDat));
   // Compare and count
   task automatic chk(input string what, input logic [31:0] seen,
      input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic rdb(input logic [7:0] adr);
      u_host.xfer(1'b0, adr, 8'h00, 4'hf, rd);
   endtask
   task automatic wrb(input logic [7:0] adr, input logic [7:0] dat);
      u_host.xfer(1'b1, adr, dat, 4'hf, rd);
   endtask
   // One event pulse, then 500 cycles to the next (10 us)
   task automatic evt(input logic [7:0] code, input logic [7:0] det);
      @(posedge sys_clk);
      evtIn <= '{valid: 1'b1, code: code, detail: det};
      @(posedge sys_clk);
      evtIn.valid <= 1'b0;
      repeat (498) @(posedge sys_clk);
   endtask
   task automatic test_done;
      $display("Compared %0d, mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // Clock, 20 ns period
   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end
   // Watchdog, well past the expected run length
   initial begin
      repeat (20000) @(posedge sys_clk);
      err_total++;
      test_done();
   end
   // Main sequence
   initial begin
      rst_b = 1'b0;
      evtIn = '0;
      ce = 1'b1;
      err_total = 0;
      n_compared = 0;
      repeat (20) @(posedge sys_clk);
      rst_b <= 1'b1;
      for (i = 0; i < 16; i++) begin
         u_host.xfer(rows[i].we, rows[i].adr, rows[i].dat, 4'hf, rd);
         if (!rows[i].we) chk("row", rd, {24'h0, rows[i].exp});
      end
      // Write with byte lane 0 off changes nothing
      u_host.xfer(1'b1, OFS_CTRL, 8'h00, 4'he, rd);
      rdb(OFS_STATUS);
      chk("sel0 low", rd, 32'h01);
      // More events than the ring holds, logging mode
      for (i = 0; i < NEVT; i++) evt(8'h10 + i[7:0], 8'h80 + i[7:0]);
      rdb(OFS_COUNT);
      chk("ring count", rd, NKEEP);
      wrb(OFS_CTRL, 8'h03);
      evt(8'h55, 8'h55);
      rdb(OFS_COUNT);
      chk("suspended", rd, NKEEP);
      wrb(OFS_IMG_PTR, 8'h00);
      rdb(OFS_STATUS);
      chk("started", rd, 32'h07);
      for (i = 0; i < NIMG; i++) begin
         rdb(OFS_IMG_DATA);
         img[i] = rd[7:0];
         chk("upper", rd[31:8], 0);
      end
      rdb(OFS_STATUS);
      chk("done", rd, 32'h0f);
      rdb(OFS_IMG_DATA);
      chk("past end", rd, 0);
      chk("start", {img[0], img[1]}, HDR_BYTES);
      chk("length", {img[2], img[3]}, NIMG - HDR_BYTES);
      chk("status", img[4], 8'h07);
      chk("byte5", img[5], 0);
      chk("version", {img[10], img[11]}, 16'h0207);
      chk("fw", {img[14], img[15], img[16], img[17]}, FW);
      chk("id", {img[18], img[19], img[20], img[21]}, MID);
      chk("cfg", {img[22], img[23]}, 16'ha53c);
      chk("cfg end", img[HDR_BYTES + CFG_LAST], 8'h5a);
      chk("n", {img[210], img[211]}, NKEEP);
      for (i = 0; i < NKEEP; i++) begin
         e = HDR_BYTES + ENTRY_BASE + ENTRY_BYTES * i;
         ts[i] = {img[e], img[e+1], img[e+2], img[e+3]};
         chk("code", img[e+4], 8'h10 + 8'(NEVT - NKEEP + i));
         chk("detail", img[e+5], 8'h80 + 8'(NEVT - NKEEP + i));
         if (i > 0) chk("tstep", ts[i] - ts[i-1], 10);
      end
      // Deactivate clears the ring and stops recording
      wrb(OFS_CTRL, 8'h00);
      rdb(OFS_COUNT);
      chk("cleared", rd, 0);
      rdb(OFS_STATUS);
      chk("off status", rd, 0);
      evt(8'h01, 8'h01);
      rdb(OFS_COUNT);
      chk("off count", rd, 0);
      // Reset in mid-run restores defaults
      @(posedge sys_clk);
      rst_b <= 1'b0;
      repeat (3) @(posedge sys_clk);
      rst_b <= 1'b1;
      rdb(OFS_STATUS);
      chk("rst status", rd, 32'h03);
      // Clock enable low freezes recording; logging resumes after it
      wrb(OFS_CTRL, 8'h01);
      ce <= 1'b0;
      evt(8'h21, 8'h21);
      ce <= 1'b1;
      evt(8'h22, 8'h22);
      rdb(OFS_COUNT);
      chk("ce frozen", rd, 1);
      test_done();
   end
endmodule
`default_nettype wire
